// >>> pkg/fault_pkg.sv
// Purpose: Shared constants and types for the pulse channel fault reporting block.
// Assumes: Two channels, one error byte per channel, 50 MHz system clock.
// Notes: Status bytes and module error codes of a rejected record live here.
`default_nettype none
package fault_pkg;
    localparam int CLK_HZ = 50_000_000;
    localparam int NUM_CH = 2;
    // Error byte bit positions.
    localparam int BIT_SUPPLY_UV = 0;
    localparam int BIT_SENSOR = 1;
    localparam int BIT_LOAD = 2;
    localparam int BIT_PULSE = 3;
    localparam int BIT_OUT_A = 4;
    localparam int BIT_OUT_B = 5;
    localparam int BIT_SETPOINT = 6;
    localparam int BIT_SLOT = 7;
    // Feedback byte offsets per channel.
    localparam logic [3:0] CH0_ERR_OFFSET = 4'h0;
    localparam logic [3:0] CH1_ERR_OFFSET = 4'h8;
    // Status bytes of a rejected parameter record write.
    localparam logic [7:0] STAT_WRITE_ERR = 8'hDF;
    localparam logic [7:0] STAT_CLASS = 8'h80;
    localparam logic [7:0] STAT_MODULE = 8'hE1;
    localparam logic [7:0] CODE_NONE = 8'h00;
    localparam logic [7:0] CODE_CUR_HS = 8'h25;
    localparam logic [7:0] CODE_LIMITS = 8'h27;
    localparam logic [7:0] CODE_DITHER = 8'h28;
    localparam logic [7:0] CODE_SUBST = 8'h29;
    // Dithering period floor: four PWM periods and 2 ms, periods given in microseconds.
    localparam int DITHER_MIN_PWM_PERIODS = 4;
    localparam int DITHER_MIN_US = 2000;
    localparam logic [31:0] DITHER_MIN_TIME_US = 32'(DITHER_MIN_US);
    // Indicator flash half period: 250 ms.
    localparam int FLASH_HALF_MS = 250;
    localparam int FLASH_HALF_CYC = (CLK_HZ / 1000) * FLASH_HALF_MS;
    localparam logic [23:0] FLASH_HALF_CNT = 24'(FLASH_HALF_CYC - 1);
    typedef enum logic [2:0] {
        MODE_PULSE = 3'b000,
        MODE_PWM = 3'b001,
        MODE_FREQ = 3'b010,
        MODE_ONOFF = 3'b011,
        MODE_TRAIN = 3'b100,
        MODE_MOTOR = 3'b101
    } mode_type;
    typedef enum logic [1:0] {
        IND_OFF = 2'b00,
        IND_GREEN = 2'b01,
        IND_RED_ON = 2'b10,
        IND_RED_OFF = 2'b11
    } ind_type;
endpackage
`default_nettype wire

// >>> pkg/fault_if.sv
// Purpose: Carries one channel's raw fault levels into the flag logic.
// Assumes: All levels synchronous to clk_sys.
// Notes: The core drives, the flag module samples.
`default_nettype none
interface fault_if;
    logic supply_present;
    logic supply_uv;
    logic sensor_fault;
    logic load_fail;
    logic pulse_err;
    logic short_a;
    logic short_b;
    logic drive_a;
    logic drive_b;
    logic setpoint_bad;
    logic slot_bad;
    logic slot_permanent;
    logic diagnostic_indicator_a_en;
    logic diagnostic_indicator_b_en;
    logic [7:0] flags;
    modport src (output supply_present, supply_uv, sensor_fault, load_fail, pulse_err,
        short_a, short_b, drive_a, drive_b, setpoint_bad, slot_bad, slot_permanent,
        diagnostic_indicator_a_en, diagnostic_indicator_b_en, input flags);
    modport dst (input supply_present, supply_uv, sensor_fault, load_fail, pulse_err,
        short_a, short_b, drive_a, drive_b, setpoint_bad, slot_bad, slot_permanent,
        diagnostic_indicator_a_en, diagnostic_indicator_b_en, output flags);
endinterface
`default_nettype wire

// >>> hw/channel_flags.sv
// Purpose: Builds one channel's error byte from fault levels.
// Assumes: Levels are clean and synchronous.
// Notes: Flags track their causes; no latching.
`default_nettype none
module channel_flags
    import fault_pkg::*;
(
    input wire logic clk_sys,
    input wire logic sys_rst,
    fault_if.dst fin,
    input wire logic pulse_mode
);
    logic [7:0] flags_d;
    logic [7:0] flags_q;
    always_comb begin
        flags_d = '0;
        flags_d[BIT_SUPPLY_UV] = fin.supply_present & fin.supply_uv;
        flags_d[BIT_SENSOR] = fin.sensor_fault;
        flags_d[BIT_LOAD] = fin.load_fail;
        flags_d[BIT_PULSE] = fin.pulse_err & pulse_mode;
        flags_d[BIT_OUT_A] = fin.short_a & fin.diagnostic_indicator_a_en;
        // line B fault or both high.
        flags_d[BIT_OUT_B] = (fin.short_b & fin.diagnostic_indicator_b_en) | (fin.drive_a & fin.drive_b);
        flags_d[BIT_SETPOINT] = fin.setpoint_bad;
        flags_d[BIT_SLOT] = fin.slot_bad & fin.slot_permanent;
    end
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            flags_q <= '0;
        end else begin
            flags_q <= flags_d;
        end
    end
    assign fin.flags = flags_q;
    supply_absent_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        !fin.supply_present |=> !flags_q[BIT_SUPPLY_UV])
        else $error("undervoltage flag set with supply absent");
    both_high_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (fin.drive_a && fin.drive_b) |=> flags_q[BIT_OUT_B])
        else $error("both lines high not flagged");
    line_a_gate_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        !fin.diagnostic_indicator_a_en |=> !flags_q[BIT_OUT_A])
        else $error("line A flag set while diagnostics off");
    line_b_gate_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (!fin.diagnostic_indicator_b_en && !(fin.drive_a && fin.drive_b)) |=> !flags_q[BIT_OUT_B])
        else $error("line B flag set while diagnostics off");
    pulse_gate_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        !pulse_mode |=> !flags_q[BIT_PULSE])
        else $error("pulse flag set outside pulse modes");
    sensor_follow_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        flags_q[BIT_SENSOR] == $past(fin.sensor_fault))
        else $error("sensor flag does not follow its cause");
endmodule
`default_nettype wire

// >>> hw/record_check.sv
// Purpose: Validates a written parameter record and forms its status word.
// Assumes: Record fields are stable while rec_write is high.
// Notes: Checks in code order; the last failing check gives the code.
`default_nettype none
module record_check
    import fault_pkg::*;
(
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic rec_write,
    input wire logic [2:0] rec_mode,
    input wire logic rec_current_ctrl,
    input wire logic rec_high_speed,
    input wire logic rec_dither_en,
    input wire logic [15:0] rec_high_limit,
    input wire logic [15:0] rec_low_limit,
    input wire logic [31:0] rec_dither_us,
    input wire logic [31:0] rec_pwm_period_us,
    input wire logic rec_subst_a,
    input wire logic rec_subst_b,
    output logic rec_done,
    output logic rec_accepted,
    output logic [31:0] rec_status
);
    logic [7:0] code;
    logic is_pwm;
    logic done_d, done_q, acc_d, acc_q;
    logic [31:0] stat_d, stat_q;
    logic [33:0] four_periods;
    always_comb begin
        is_pwm = (rec_mode == MODE_PWM);
        four_periods = 34'(rec_pwm_period_us) * 34'(DITHER_MIN_PWM_PERIODS);
        code = CODE_NONE;
        if (rec_subst_a && rec_subst_b) begin
            code = CODE_SUBST;
        end
        if (is_pwm && rec_dither_en && ((34'(rec_dither_us) < four_periods)
                || (rec_dither_us < DITHER_MIN_TIME_US))) begin
            code = CODE_DITHER;
        end
        if (is_pwm && rec_current_ctrl && (rec_high_limit <= rec_low_limit)) begin
            code = CODE_LIMITS;
        end
        if (is_pwm && rec_current_ctrl && rec_high_speed) begin
            code = CODE_CUR_HS;
        end
        done_d = rec_write;
        acc_d = rec_write ? (code == CODE_NONE) : acc_q;
        stat_d = stat_q;
        if (rec_write) begin
            stat_d = (code == CODE_NONE) ? 32'h0000_0000
                : {STAT_WRITE_ERR, STAT_CLASS, STAT_MODULE, code};
        end
    end
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            done_q <= 1'b0;
            acc_q <= 1'b1;
            stat_q <= 32'h0000_0000;
        end else begin
            done_q <= done_d;
            acc_q <= acc_d;
            stat_q <= stat_d;
        end
    end
    assign rec_done = done_q;
    assign rec_accepted = acc_q;
    assign rec_status = stat_q;
    // code for current plus high speed.
    cur_hs_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (rec_write && rec_mode == MODE_PWM && rec_current_ctrl && rec_high_speed)
        |=> (rec_status == 32'hDF80_E125) && !rec_accepted)
        else $error("current plus high speed not rejected");
    subst_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (rec_write && rec_subst_a && rec_subst_b && rec_mode != MODE_PWM)
        |=> rec_status == 32'hDF80_E129)
        else $error("both substitutes high not rejected");
    limits_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (rec_write && rec_mode == MODE_PWM && rec_current_ctrl && !rec_high_speed
        && rec_high_limit <= rec_low_limit) |=> rec_status[7:0] == 8'h27)
        else $error("limit order not rejected");
endmodule
`default_nettype wire

// >>> hw/pulse_fault_report.sv
// Purpose: Fault reporting for a two channel pulse output module.
// Assumes: All inputs synchronous to clk_sys; fault causes come as levels.
// Notes: Error bytes read on the feedback port; diagnostics raised as levels.
// Contract
// - PWM rejects current control plus high speed
// - PWM current control needs high above low
// - Dithering period at least 4 periods, 2ms
// - Both substitute values one is rejected
// - Bit 0 undervoltage, clear when supply absent
// - Bit 1 sensor supply fault
// - Bit 2 single update load failure
// - Bit 3 pulse output error in pulse modes
// - Bit 4 line A short or overload
// - Bit 5 line B fault or both high
// - Bit 6 setpoint value invalid
// - Bit 7 slot invalid under permanent update
// - Indicator flashes red while diagnostic pending
// - Keep operating unchanged during errors in run; the code holds line B low while line A is requested
// - Short or overload sends enabled diagnostic
// - Group diagnostics gates supply, sensor, temperature
// - Line A detection only when enabled
// - Line B detection only when enabled
// - Rejected write returns four status bytes
`default_nettype none
module pulse_fault_report
    import fault_pkg::*;
(
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic configured,
    input wire logic [5:0] ch_mode,
    input wire logic supply_present,
    input wire logic supply_uv,
    input wire logic sensor_fault,
    input wire logic over_temp,
    input wire logic [1:0] load_fail,
    input wire logic [1:0] pulse_err,
    input wire logic [1:0] short_a,
    input wire logic [1:0] short_b,
    input wire logic [1:0] software_drive_a,
    input wire logic [1:0] software_drive_b,
    input wire logic [1:0] module_output_control,
    input wire logic [1:0] output_setpoint_invalid,
    input wire logic [1:0] slot_value_invalid,
    input wire logic [1:0] slot_permanent,
    input wire logic [1:0] group_diagnostic_indicator_en,
    input wire logic [1:0] diagnostic_indicator_a_en,
    input wire logic [1:0] diagnostic_indicator_b_en,
    input wire logic [1:0] output_line_a_req,
    input wire logic [1:0] output_line_b_req,
    output logic [1:0] output_line_a,
    output logic [1:0] output_line_b,
    input wire logic [3:0] fb_addr,
    output logic [7:0] fb_data,
    input wire logic rec_write,
    input wire logic [2:0] rec_mode,
    input wire logic rec_current_ctrl,
    input wire logic rec_high_speed,
    input wire logic rec_dither_en,
    input wire logic [15:0] rec_high_limit,
    input wire logic [15:0] rec_low_limit,
    input wire logic [31:0] rec_dither_us,
    input wire logic [31:0] rec_pwm_period_us,
    input wire logic rec_subst_a,
    input wire logic rec_subst_b,
    output logic rec_done,
    output logic rec_accepted,
    output logic [31:0] rec_status,
    output logic [1:0] diagnostic_indicator_pending,
    output logic diagnostic_indicator_indicator_green,
    output logic diagnostic_indicator_indicator_red
);
    ////////////////////////////////////////////////////////////////////////////
    logic [7:0] ch_flags [NUM_CH];
    logic [1:0] pulse_mode;

    function automatic logic is_pulse_mode(input logic [2:0] m);
        return (m == MODE_PULSE) || (m == MODE_ONOFF) || (m == MODE_TRAIN);
    endfunction

    fault_if fch0 ();
    fault_if fch1 ();

    for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
        assign pulse_mode[c] = is_pulse_mode(ch_mode[3*c +: 3]);
    end

    assign fch0.supply_present = supply_present;
    assign fch0.supply_uv = supply_uv;
    assign fch0.sensor_fault = sensor_fault;
    assign fch0.load_fail = load_fail[0];
    assign fch0.pulse_err = pulse_err[0];
    assign fch0.short_a = short_a[0];
    assign fch0.short_b = short_b[0];
    assign fch0.drive_a = software_drive_a[0] & module_output_control[0];
    assign fch0.drive_b = software_drive_b[0] & module_output_control[0];
    assign fch0.setpoint_bad = output_setpoint_invalid[0];
    assign fch0.slot_bad = slot_value_invalid[0];
    assign fch0.slot_permanent = slot_permanent[0];
    assign fch0.diagnostic_indicator_a_en = diagnostic_indicator_a_en[0];
    assign fch0.diagnostic_indicator_b_en = diagnostic_indicator_b_en[0];
    assign fch1.supply_present = supply_present;
    assign fch1.supply_uv = supply_uv;
    assign fch1.sensor_fault = sensor_fault;
    assign fch1.load_fail = load_fail[1];
    assign fch1.pulse_err = pulse_err[1];
    assign fch1.short_a = short_a[1];
    assign fch1.short_b = short_b[1];
    assign fch1.drive_a = software_drive_a[1] & module_output_control[1];
    assign fch1.drive_b = software_drive_b[1] & module_output_control[1];
    assign fch1.setpoint_bad = output_setpoint_invalid[1];
    assign fch1.slot_bad = slot_value_invalid[1];
    assign fch1.slot_permanent = slot_permanent[1];
    assign fch1.diagnostic_indicator_a_en = diagnostic_indicator_a_en[1];
    assign fch1.diagnostic_indicator_b_en = diagnostic_indicator_b_en[1];

    channel_flags u_flags0 (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .fin(fch0),
        .pulse_mode(pulse_mode[0])
    );
    channel_flags u_flags1 (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .fin(fch1),
        .pulse_mode(pulse_mode[1])
    );
    assign ch_flags[0] = fch0.flags;
    assign ch_flags[1] = fch1.flags;

    ////////////////////////////////////////////////////////////////////////////
    // Feedback port: error bytes at their offsets, other bytes read zero.
    logic [7:0] fb_d, fb_q;
    always_comb begin
        case (fb_addr)
            CH0_ERR_OFFSET: fb_d = ch_flags[0];
            CH1_ERR_OFFSET: fb_d = ch_flags[1];
            default: fb_d = 8'h00;
        endcase
    end
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            fb_q <= 8'h00;
        end else begin
            fb_q <= fb_d;
        end
    end
    assign fb_data = fb_q;

    ////////////////////////////////////////////////////////////////////////////
    // Outputs keep running through faults; only the both-high attempt is held off,
    // since driving both lines of a bridge high is the fault being reported.
    logic [1:0] out_a_d, out_a_q, out_b_d, out_b_q;
    always_comb begin
        out_a_d = output_line_a_req;
        out_b_d = output_line_b_req & ~output_line_a_req;
    end
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            out_a_q <= 2'b00;
            out_b_q <= 2'b00;
        end else begin
            out_a_q <= out_a_d;
            out_b_q <= out_b_d;
        end
    end
    assign output_line_a = out_a_q;
    assign output_line_b = out_b_q;

    ////////////////////////////////////////////////////////////////////////////
    logic [1:0] diagnostic_indicator_d, diagnostic_indicator_q;
    always_comb begin
        for (int c = 0; c < NUM_CH; c++) begin
            diagnostic_indicator_d[c] = ch_flags[c][BIT_OUT_A] | (short_b[c] & diagnostic_indicator_b_en[c])
                | (group_diagnostic_indicator_en[c] & (ch_flags[c][BIT_SUPPLY_UV] | ~supply_present
                | ch_flags[c][BIT_SENSOR] | over_temp));
        end
    end
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            diagnostic_indicator_q <= 2'b00;
        end else begin
            diagnostic_indicator_q <= diagnostic_indicator_d;
        end
    end
    assign diagnostic_indicator_pending = diagnostic_indicator_q;

    ////////////////////////////////////////////////////////////////////////////
    ind_type ind_d, ind_q;
    logic [23:0] fl_d, fl_q;
    always_comb begin
        ind_d = ind_q;
        fl_d = fl_q;
        case (ind_q)
            IND_OFF: begin
                ind_d = configured ? IND_GREEN : IND_OFF;
            end
            IND_GREEN: begin
                fl_d = '0;
                if (|diagnostic_indicator_q) begin
                    ind_d = IND_RED_ON;
                end
            end
            IND_RED_ON, IND_RED_OFF: begin
                if (!(|diagnostic_indicator_q)) begin
                    ind_d = IND_GREEN;
                end else if (fl_q == FLASH_HALF_CNT) begin
                    fl_d = '0;
                    ind_d = (ind_q == IND_RED_ON) ? IND_RED_OFF : IND_RED_ON;
                end else begin
                    fl_d = fl_q + 24'h00_0001;
                end
            end
            default: ind_d = IND_OFF;
        endcase
        if (!configured) begin
            ind_d = IND_OFF;
        end
    end
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            ind_q <= IND_OFF;
            fl_q <= '0;
        end else begin
            ind_q <= ind_d;
            fl_q <= fl_d;
        end
    end
    assign diagnostic_indicator_indicator_green = (ind_q == IND_GREEN);
    assign diagnostic_indicator_indicator_red = (ind_q == IND_RED_ON);

    ////////////////////////////////////////////////////////////////////////////
    record_check u_rec (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .rec_write(rec_write),
        .rec_mode(rec_mode),
        .rec_current_ctrl(rec_current_ctrl),
        .rec_high_speed(rec_high_speed),
        .rec_dither_en(rec_dither_en),
        .rec_high_limit(rec_high_limit),
        .rec_low_limit(rec_low_limit),
        .rec_dither_us(rec_dither_us),
        .rec_pwm_period_us(rec_pwm_period_us),
        .rec_subst_a(rec_subst_a),
        .rec_subst_b(rec_subst_b),
        .rec_done(rec_done),
        .rec_accepted(rec_accepted),
        .rec_status(rec_status)
    );

    ////////////////////////////////////////////////////////////////////////////
    // return to green.
    green_back_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (configured && diagnostic_indicator_q == 2'b00 && $past(configured) && ind_q != IND_OFF)
        |=> diagnostic_indicator_indicator_green)
        else $error("indicator not green after faults cleared");
    red_entry_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (configured && ind_q == IND_GREEN && diagnostic_indicator_q != 2'b00) |=> diagnostic_indicator_indicator_red)
        else $error("indicator not red with fault pending");
    // group gate off.
    // The line A cause reaches the alarm through its registered flag, one cycle late.
    group_off_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (group_diagnostic_indicator_en == 2'b00 && short_b == 2'b00
        && {ch_flags[1][BIT_OUT_A], ch_flags[0][BIT_OUT_A]} == 2'b00)
        |=> diagnostic_indicator_pending == 2'b00)
        else $error("diagnostic raised with group diagnostics off");
    short_diagnostic_indicator_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (short_b[0] && diagnostic_indicator_b_en[0]) |=> diagnostic_indicator_pending[0])
        else $error("line B short not reported");
    keep_run_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        output_line_a_req[0] |=> output_line_a[0])
        else $error("output stopped during fault");
    fb_map0_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (fb_addr == CH0_ERR_OFFSET) |=> fb_data == $past(ch_flags[0]))
        else $error("channel 0 error byte misplaced");
    fb_map1_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (fb_addr == CH1_ERR_OFFSET) |=> fb_data == $past(ch_flags[1]))
        else $error("channel 1 error byte misplaced");
    rec_answer_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        rec_write |=> rec_done)
        else $error("record write not answered");
    dither_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (rec_write && rec_mode == MODE_PWM && rec_dither_en && !rec_current_ctrl
        && rec_dither_us < 32'd2000) |=> rec_status[7:0] == 8'h28)
        else $error("short dithering period not rejected");
endmodule
`default_nettype wire

// >>> dv/feedback_reader.sv
// Purpose: Controller-side model that polls one channel's feedback error byte.
// Assumes: Channel select changes only at the falling clock edge.
// Notes: Captures the byte one edge after the device presents it.
`default_nettype none
module feedback_reader (
    input wire logic clk_sys,
    input wire logic sel_ch1,
    output logic [3:0] fb_addr,
    input wire logic [7:0] fb_data,
    output logic [7:0] byte_q
);
    timeunit 1ns;
    timeprecision 1ps;
    // The controller only ever addresses the two documented feedback bytes.
    assign fb_addr = sel_ch1 ? 4'h8 : 4'h0;
    always_ff @(posedge clk_sys) begin
        byte_q <= fb_data;
    end
endmodule
`default_nettype wire

// >>> dv/pulse_fault_report_tb.sv
// Purpose: Self-checking bench for the fault reporting block.
// Assumes: Inputs driven at the falling edge; register reads go through the reader model.
// Notes: The flash period is too long to watch, so only entry to red and return are seen.
`default_nettype none
module pulse_fault_report_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import fault_pkg::*;
    logic clk_sys = 0, sys_rst = 1, configured = 0, sel_ch1 = 0, rec_write = 0;
    logic supply_present = 1, supply_uv = 0, sensor_fault = 0, over_temp = 0;
    logic [5:0] ch_mode = '0;
    logic [1:0] load_fail = 0, pulse_err = 0, short_a = 0, short_b = 0;
    logic [1:0] software_drive_a = 0, software_drive_b = 0, module_output_control = 0;
    logic [1:0] output_setpoint_invalid = 0, slot_value_invalid = 0, slot_permanent = 3;
    logic [1:0] group_diagnostic_indicator_en = 0, diagnostic_indicator_a_en = 3, diagnostic_indicator_b_en = 3;
    logic [1:0] output_line_a_req = 0, output_line_b_req = 0, output_line_a, output_line_b;
    logic [1:0] diagnostic_indicator_pending;
    logic [3:0] fb_addr;
    logic [7:0] fb_data, byte_q;
    logic [2:0] rec_mode = '0;
    logic rec_current_ctrl = 0, rec_high_speed = 0, rec_dither_en = 0;
    logic rec_subst_a = 0, rec_subst_b = 0, rec_done, rec_accepted;
    logic [15:0] rec_high_limit = '0, rec_low_limit = '0;
    logic [31:0] rec_dither_us = '0, rec_pwm_period_us = '0, rec_status;
    logic diagnostic_indicator_indicator_green, diagnostic_indicator_indicator_red;
    int fails = 0, num_checks = 0, cycles = 0;
    pulse_fault_report DUT (.*);
    feedback_reader reader (.clk_sys(clk_sys), .sel_ch1(sel_ch1), .fb_addr(fb_addr),
        .fb_data(fb_data), .byte_q(byte_q));
    always #10 clk_sys = ~clk_sys;
    ////////////////////////////////////////////////////////////////////////////////
    task automatic final_report();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // A hung wait would otherwise stall the run forever.
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 20000) begin
            fails++;
            final_report();
        end
    end
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            fails++;
            $display("unexpected %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic rd(input int c, input logic [7:0] e, input string nm);
        sel_ch1 = (c == 1);
        repeat (4) @(posedge clk_sys);
        @(negedge clk_sys);
        chk(nm, 32'(e), 32'(byte_q));
    endtask
    task automatic cause(input int b, input int c, input logic v);
        case (b)
            0: supply_uv = v;
            1: sensor_fault = v;
            2: load_fail[c] = v;
            3: pulse_err[c] = v;
            4: short_a[c] = v;
            5: short_b[c] = v;
            6: output_setpoint_invalid[c] = v;
            default: slot_value_invalid[c] = v;
        endcase
    endtask
    task automatic wr(input logic [2:0] m, input logic [4:0] f, input logic [15:0] hi,
        input logic [31:0] du, input logic [31:0] pu, input logic [7:0] code);
        {rec_current_ctrl, rec_high_speed, rec_dither_en, rec_subst_a, rec_subst_b} = f;
        rec_mode = m;
        rec_high_limit = hi;
        rec_low_limit = 16'h000a;
        rec_dither_us = du;
        rec_pwm_period_us = pu;
        rec_write = 1;
        @(negedge clk_sys);
        rec_write = 0;
        chk("rec_done", 1, 32'(rec_done));
        chk("rec_accepted", 32'(code == CODE_NONE), 32'(rec_accepted));
        chk("rec_status", (code == CODE_NONE) ? '0
            : {STAT_WRITE_ERR, STAT_CLASS, STAT_MODULE, code}, rec_status);
        // A gap cycle keeps the strobe from being lowered and raised in one step.
        @(negedge clk_sys);
        chk("rec_done low", 0, 32'(rec_done));
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20) @(posedge clk_sys);
        @(negedge clk_sys);
        sys_rst = 0;
        configured = 1;
        wr(3'd1, 5'b11000, 16'h0014, 32'd0, 32'd0, CODE_CUR_HS);
        wr(3'd1, 5'b10000, 16'h000a, 32'd0, 32'd0, CODE_LIMITS);
        wr(3'd1, 5'b10000, 16'h000b, 32'd0, 32'd0, CODE_NONE);
        wr(3'd1, 5'b00100, 16'h0000, 32'd3999, 32'd1000, CODE_DITHER);
        wr(3'd1, 5'b00100, 16'h0000, 32'd1999, 32'd100, CODE_DITHER);
        wr(3'd1, 5'b00100, 16'h0000, 32'd4000, 32'd1000, CODE_NONE);
        wr(3'd3, 5'b00011, 16'h0000, 32'd0, 32'd0, CODE_SUBST);
        wr(3'd2, 5'b00010, 16'h0000, 32'd0, 32'd0, CODE_NONE);
        $display("record checks done");
        for (int c = 0; c < 2; c++) begin
            for (int b = 0; b < 8; b++) begin
                cause(b, c, 1);
                rd(c, 8'(1 << b), "error byte set");
                cause(b, c, 0);
                rd(c, 8'h00, "error byte clear");
            end
        end
        $display("flag walk done");
        supply_present = 0;
        supply_uv = 1;
        rd(0, 8'h00, "undervoltage absent");
        supply_present = 1;
        supply_uv = 0;
        diagnostic_indicator_a_en = 0;
        short_a = 3;
        rd(1, 8'h00, "line a diagnostic_indicator off");
        diagnostic_indicator_b_en = 0;
        short_a = 0;
        short_b = 3;
        rd(1, 8'h00, "line b diagnostic_indicator off");
        {diagnostic_indicator_a_en, diagnostic_indicator_b_en, short_b, slot_permanent, slot_value_invalid} = 10'b1111000011;
        rd(0, 8'h00, "slot single update");
        {slot_permanent, slot_value_invalid, pulse_err, ch_mode} = 12'b110011_001001;
        rd(0, 8'h00, "pulse in pwm");
        {pulse_err, ch_mode} = '0;
        {software_drive_a, software_drive_b, module_output_control} = 6'b010101;
        {output_line_a_req, output_line_b_req} = 4'b0101;
        rd(0, 8'h20, "both lines high");
        chk("line b", 0, 32'(output_line_b[0]));
        chk("line a", 1, 32'(output_line_a[0]));
        {software_drive_a, software_drive_b, module_output_control} = '0;
        {output_line_a_req, output_line_b_req} = '0;
        $display("gating done");
        chk("green idle", 1, 32'(diagnostic_indicator_indicator_green));
        short_a = 1;
        rd(0, 8'h10, "line a short");
        chk("pending", 1, 32'(diagnostic_indicator_pending));
        chk("red", 1, 32'({diagnostic_indicator_indicator_red, diagnostic_indicator_indicator_green} == 2'b10));
        short_a = 0;
        rd(0, 8'h00, "short gone");
        chk("green back", 1, 32'(diagnostic_indicator_indicator_green));
        over_temp = 1;
        rd(0, 8'h00, "temp");
        chk("group off", 0, 32'(diagnostic_indicator_pending));
        group_diagnostic_indicator_en = 3;
        rd(0, 8'h00, "temp");
        chk("group on", 3, 32'(diagnostic_indicator_pending));
        $display("diagnostics done");
        final_report();
    end
endmodule
`default_nettype wire
